// ---- hdl/datalog_defines.vh ----
`ifndef DATALOG_DEFINES_VH
`define DATALOG_DEFINES_VH

// register byte addresses
`define REG_SAMPLE_RATE      16'h000D
`define REG_CONTROL1         16'h000E
`define REG_CONTROL2         16'h000F
`define REG_START_DELAY_LOW  16'h0012
`define REG_START_DELAY_HIGH 16'h0013
`define REG_STATUS1          16'h0014
`define REG_COUNT_LOW        16'h0018
`define REG_COUNT_MID        16'h0019
`define REG_COUNT_HIGH       16'h001A
`define REG_STAMP_LOW        16'h001C
`define REG_STAMP_MID        16'h001D
`define REG_STAMP_HIGH       16'h001E
`define REG_CUR_TEMP         16'h0030
`define REG_CUR_ADC1         16'h0031
`define REG_CUR_ADC2         16'h0032
`define REG_CUR_ADC3         16'h0033

// log memory window
`define LOG_FIRST            16'h1000
`define LOG_LAST             16'h17FF
`define LOG_PTR_LAST         11'h7FF

// field positions
`define CTL1_SE_BIT          0
`define CTL1_WRAP_BIT        3
`define STAT1_MIP_BIT        5

// reset values
`define SAMPLE_RATE_RST      8'h00
`define CONTROL1_RST         8'h00
`define CONTROL2_RST         8'h01
`define START_DELAY_RST      16'h0000

// fixed data values
`define TEMP_OFF_VALUE       8'hFF
`define ADC_OFF_VALUE        8'h00
`define PAD_VALUE            8'h00

// timing
`define CLK_MHZ              25
`define IND_PULSE_US         62500
`define IND_PERIOD_US        500000
`define START_HOLD_US        500000

`endif

// ---- hdl/pair_buffer.v ----
module pair_buffer (
    input  wire       clk_sys,  // system clock
    input  wire       rst_n,    // sync reset, active low
    input  wire       inValid,  // producer has a byte
    output wire       inReady,  // room for a byte
    input  wire [7:0] inData,   // byte in
    output wire       outValid, // byte available
    input  wire       outReady, // consumer takes byte
    output wire [7:0] outData   // oldest byte
);
    reg  [7:0] slot0;
    reg  [7:0] slot1;
    reg  [1:0] fill;
    wire       push;
    wire       pop;

    assign inReady  = (fill != 2'h2);
    assign outValid = (fill != 2'h0);
    assign outData  = slot0;
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            slot0 <= 8'h00;
            slot1 <= 8'h00;
            fill  <= 2'h0;
        end else begin
            if (push && pop) begin
                if (fill == 2'h1) begin
                    slot0 <= inData;
                end else begin
                    slot0 <= slot1;
                    slot1 <= inData;
                end
            end else if (push) begin
                if (fill == 2'h0) begin
                    slot0 <= inData;
                end else begin
                    slot1 <= inData;
                end
                fill <= fill + 2'h1;
            end else if (pop) begin
                slot0 <= slot1;
                fill  <= fill - 2'h1;
            end
        end
    end
endmodule

// ---- hdl/indicator_pulser.v ----
module indicator_pulser #(
    parameter integer PULSE_CYC  = 1562500,
    parameter integer PERIOD_CYC = 12500000
) (
    input  wire clk_sys,   // system clock
    input  wire rst_n,     // sync reset, active low
    input  wire trigger,   // one-cycle start request
    output reg  inLimitN,  // first indicator, low = lit
    output reg  outLimitN  // second indicator, low = lit
);
    localparam [23:0] PULSE_CNT  = PULSE_CYC[23:0];
    localparam [23:0] PERIOD_CNT = PERIOD_CYC[23:0];

    reg        active;
    reg [23:0] phase;
    reg [2:0]  left;
    wire [23:0] phaseInc;

    assign phaseInc = phase + 24'h000001;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            active    <= 1'b0;
            phase     <= 24'h000000;
            left      <= 3'h0;
            inLimitN  <= 1'b1;
            outLimitN <= 1'b1;
        end else if (trigger) begin
            active    <= 1'b1;
            phase     <= 24'h000000;
            left      <= 3'h4;
            inLimitN  <= 1'b0;
            outLimitN <= 1'b0;
        end else if (active) begin
            if (phaseInc == PERIOD_CNT) begin
                phase <= 24'h000000;
                if (left == 3'h1) begin
                    active    <= 1'b0;
                    inLimitN  <= 1'b1;
                    outLimitN <= 1'b1;
                end else begin
                    left      <= left - 3'h1;
                    inLimitN  <= 1'b0;
                    outLimitN <= 1'b0;
                end
            end else begin
                phase     <= phaseInc;
                inLimitN  <= (phaseInc >= PULSE_CNT);
                outLimitN <= (phaseInc >= PULSE_CNT);
            end
        end
    end
endmodule

// ---- hdl/datalog_mission_sequencer.v ----
// Operation
// - samples stored only in 1000h..17FFh log
// - select bit enables channel, else fixed value
// - channels sampled in ascending select order
// - next channel follows previous conversion, consecutive
// - three channels: pad byte after each event
// - capacity 512, 1024 or 2048 per channel
// - pin ignored without enable; rate write starts
// - with enable, rate write plus half-second press
// - sampling interval equals sample rate minutes
// - host writing zero to flag ends mission
// - start: four joint low pulses, flag set
// - pulses 62.5 ms long, every half second
// - start delay 16-bit minutes at 12h/13h
// - delay counts on rollovers, then first sample
// - wraparound bit: continue at 1000h when full
// - no wraparound: stop after 2048 samples
// - time stamp only for the first sample
// - running count of all samples and pad bytes acquired
// - count three bytes, low byte lowest address
// - host writes into log region are ignored
`include "datalog_defines.vh"

module datalog_mission_sequencer #(
    parameter integer PULSE_CYC  = `IND_PULSE_US * `CLK_MHZ,
    parameter integer PERIOD_CYC = `IND_PERIOD_US * `CLK_MHZ,
    parameter integer HOLD_CYC   = `START_HOLD_US * `CLK_MHZ
) (
    input  wire        clk_sys,            // system clock, 25 MHz
    input  wire        rst_n,              // sync reset, active low
    input  wire        regWrEn,            // register write strobe
    input  wire        regRdEn,            // register read strobe
    input  wire [15:0] regAddr,            // register byte address
    input  wire [7:0]  regWrData,          // write data
    output reg  [7:0]  regRdData,          // read data, one cycle later
    output reg         regRdValid,         // read data valid pulse
    input  wire        secRollover,        // seconds 59 to 00 tick
    input  wire [23:0] rtcStamp,           // current clock time
    input  wire        startPinN,          // start pushbutton, low = pressed
    output reg         convStart,          // conversion request pulse
    output reg  [1:0]  convChannel,        // channel to convert
    input  wire        convDone,           // conversion finished pulse
    input  wire [7:0]  convData,           // conversion result
    output reg         missionActiveFlag,  // mission in progress
    output wire        inLimitIndicatorN,  // first indicator, low = lit
    output wire        outLimitIndicatorN  // second indicator, low = lit
);
    localparam [1:0] M_IDLE  = 2'h0;
    localparam [1:0] M_ARMED = 2'h1;
    localparam [1:0] M_DELAY = 2'h2;
    localparam [1:0] M_RUN   = 2'h3;

    localparam [1:0] S_IDLE  = 2'h0;
    localparam [1:0] S_PICK  = 2'h1;
    localparam [1:0] S_WAIT  = 2'h2;
    localparam [1:0] S_PAD   = 2'h3;

    localparam [23:0] HOLD_CNT = HOLD_CYC[23:0];

    function isLogAddr;
        input [15:0] addr;
        begin
            isLogAddr = (addr >= `LOG_FIRST) && (addr <= `LOG_LAST);
        end
    endfunction

    function [2:0] chanCount;
        input [3:0] sel;
        begin
            chanCount = {2'h0, sel[0]} + {2'h0, sel[1]} + {2'h0, sel[2]} + {2'h0, sel[3]};
        end
    endfunction

    reg  [7:0]  sampleRate;
    reg  [7:0]  control1;
    reg  [7:0]  control2;
    reg  [15:0] startDelay;
    reg  [7:0]  curValue [0:3];
    reg  [7:0]  logMem [0:2047];
    reg  [10:0] writePtr;
    reg         logFull;
    reg  [23:0] sampleCount;
    reg  [23:0] stamp;
    reg         stampTaken;
    reg  [7:0]  intervalLeft;
    reg  [23:0] holdCount;
    reg  [1:0]  mState;
    reg  [1:0]  sState;
    reg  [1:0]  chIdx;
    reg         fire;
    reg  [7:0]  readMux;

    wire        hostWr;
    wire        rateWrNz;
    wire        stopWr;
    wire        holdMet;
    wire        startEvent;
    wire        pushEnable;
    wire        wrapOn;
    wire [3:0]  chanSel;
    wire        bufInValid;
    wire        bufInReady;
    wire [7:0]  bufInData;
    wire        bufOutValid;
    wire        bufOutReady;
    wire [7:0]  bufOutData;
    wire        drain;

    assign hostWr   = regWrEn & ~isLogAddr(regAddr);
    assign rateWrNz = hostWr && (regAddr == `REG_SAMPLE_RATE) && (regWrData != 8'h00);
    assign stopWr   = hostWr && (regAddr == `REG_STATUS1) && !regWrData[`STAT1_MIP_BIT];
    assign holdMet  = (holdCount == HOLD_CNT);
    assign wrapOn   = control1[`CTL1_WRAP_BIT];
    assign chanSel  = control2[3:0];

    // armed start needs press while the start enable bit is set
    // an armed start with the button later disabled still starts on a rate write
    assign startEvent = (((mState == M_IDLE) || (mState == M_ARMED)) && rateWrNz &&
                         !control1[`CTL1_SE_BIT]) ||
                        ((mState == M_ARMED) && holdMet && control1[`CTL1_SE_BIT]);

    // press length measured only while held low
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            holdCount <= 24'h000000;
        end else if (startPinN) begin
            holdCount <= 24'h000000;
        end else if (!holdMet) begin
            holdCount <= holdCount + 24'h000001;
        end
    end

    // host-written registers
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sampleRate <= `SAMPLE_RATE_RST;
            control1   <= `CONTROL1_RST;
            control2   <= `CONTROL2_RST;
            startDelay <= `START_DELAY_RST;
        end else begin
            if (hostWr && (regAddr == `REG_SAMPLE_RATE)) begin
                sampleRate <= regWrData;
            end
            if (hostWr && (regAddr == `REG_CONTROL1)) begin
                control1 <= regWrData;
            end
            if (hostWr && (regAddr == `REG_CONTROL2)) begin
                control2 <= regWrData;
            end
            if (hostWr && (regAddr == `REG_START_DELAY_LOW)) begin
                startDelay[7:0] <= regWrData;
            end else if (hostWr && (regAddr == `REG_START_DELAY_HIGH)) begin
                startDelay[15:8] <= regWrData;
            end else if ((mState == M_DELAY) && secRollover && (startDelay != 16'h0000)) begin
                startDelay <= startDelay - 16'h0001;
            end
        end
    end

    // mission state and flag
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            mState            <= M_IDLE;
            missionActiveFlag <= 1'b0;
            intervalLeft      <= 8'h00;
            fire              <= 1'b0;
        end else begin
            fire <= 1'b0;
            if (startEvent) begin
                missionActiveFlag <= 1'b1;
                mState            <= M_DELAY;
            end else if (stopWr) begin
                missionActiveFlag <= 1'b0;
                mState            <= M_IDLE;
            end else begin
                case (mState)
                    M_IDLE: begin
                        if (rateWrNz) begin
                            mState <= M_ARMED;
                        end
                    end
                    M_ARMED: begin
                        mState <= M_ARMED;
                    end
                    M_DELAY: begin
                        if (secRollover && (startDelay == 16'h0000)) begin
                            fire         <= 1'b1;
                            intervalLeft <= sampleRate;
                            mState       <= M_RUN;
                        end
                    end
                    M_RUN: begin
                        if (secRollover) begin
                            if (intervalLeft <= 8'h01) begin
                                fire         <= 1'b1;
                                intervalLeft <= sampleRate;
                            end else begin
                                intervalLeft <= intervalLeft - 8'h01;
                            end
                        end
                    end
                    default: begin
                        mState <= M_IDLE;
                    end
                endcase
            end
        end
    end

    assign pushEnable = bufInReady;
    assign bufInValid = ((sState == S_WAIT) && convDone) || (sState == S_PAD);
    assign bufInData  = (sState == S_PAD) ? `PAD_VALUE : convData;

    // sampling event sequencer
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sState      <= S_IDLE;
            chIdx       <= 2'h0;
            convStart   <= 1'b0;
            convChannel <= 2'h0;
            stamp       <= 24'h000000;
            stampTaken  <= 1'b0;
            curValue[0] <= `TEMP_OFF_VALUE;
            curValue[1] <= `ADC_OFF_VALUE;
            curValue[2] <= `ADC_OFF_VALUE;
            curValue[3] <= `ADC_OFF_VALUE;
        end else begin
            convStart <= 1'b0;
            if (startEvent) begin
                stampTaken <= 1'b0;
            end
            if (stopWr) begin
                sState <= S_IDLE;
            end else begin
                case (sState)
                    S_IDLE: begin
                        if (fire && (chanSel != 4'h0)) begin
                            chIdx  <= 2'h0;
                            sState <= S_PICK;
                            if (!stampTaken) begin
                                stamp      <= rtcStamp;
                                stampTaken <= 1'b1;
                            end
                        end
                    end
                    S_PICK: begin
                        if (!chanSel[chIdx]) begin
                            if (chIdx == 2'h3) begin
                                sState <= (chanCount(chanSel) == 3'h3) ? S_PAD : S_IDLE;
                            end else begin
                                chIdx <= chIdx + 2'h1;
                            end
                        end else if (pushEnable) begin
                            convStart   <= 1'b1;
                            convChannel <= chIdx;
                            sState      <= S_WAIT;
                        end
                    end
                    S_WAIT: begin
                        if (convDone) begin
                            curValue[chIdx] <= convData;
                            if (chIdx == 2'h3) begin
                                sState <= (chanCount(chanSel) == 3'h3) ? S_PAD : S_IDLE;
                            end else begin
                                chIdx  <= chIdx + 2'h1;
                                sState <= S_PICK;
                            end
                        end
                    end
                    S_PAD: begin
                        if (pushEnable) begin
                            sState <= S_IDLE;
                        end
                    end
                    default: begin
                        sState <= S_IDLE;
                    end
                endcase
            end
        end
    end

    pair_buffer u_buffer (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .inValid  (bufInValid),
        .inReady  (bufInReady),
        .inData   (bufInData),
        .outValid (bufOutValid),
        .outReady (bufOutReady),
        .outData  (bufOutData)
    );

    // log read port has priority over the drain
    assign bufOutReady = ~(regRdEn & isLogAddr(regAddr));
    assign drain       = bufOutValid & bufOutReady;

    // log pointer, full flag and running count
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            writePtr    <= 11'h000;
            logFull     <= 1'b0;
            sampleCount <= 24'h000000;
        end else if (startEvent) begin
            writePtr    <= 11'h000;
            logFull     <= 1'b0;
            sampleCount <= 24'h000000;
        end else if (drain) begin
            sampleCount <= sampleCount + 24'h000001;
            if (!logFull || wrapOn) begin
                writePtr <= writePtr + 11'h001;
                logFull  <= (writePtr == `LOG_PTR_LAST) && !wrapOn;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (drain && (!logFull || wrapOn)) begin
            logMem[writePtr] <= bufOutData;
        end
    end

    // register read decode
    always @* begin
        readMux = 8'h00;
        case (regAddr)
            `REG_SAMPLE_RATE:      readMux = sampleRate;
            `REG_CONTROL1:         readMux = control1;
            `REG_CONTROL2:         readMux = control2;
            `REG_START_DELAY_LOW:  readMux = startDelay[7:0];
            `REG_START_DELAY_HIGH: readMux = startDelay[15:8];
            `REG_STATUS1:          readMux = {2'h0, missionActiveFlag, 5'h00};
            `REG_COUNT_LOW:        readMux = sampleCount[7:0];
            `REG_COUNT_MID:        readMux = sampleCount[15:8];
            `REG_COUNT_HIGH:       readMux = sampleCount[23:16];
            `REG_STAMP_LOW:        readMux = stamp[7:0];
            `REG_STAMP_MID:        readMux = stamp[15:8];
            `REG_STAMP_HIGH:       readMux = stamp[23:16];
            `REG_CUR_TEMP:         readMux = chanSel[0] ? curValue[0] : `TEMP_OFF_VALUE;
            `REG_CUR_ADC1:         readMux = chanSel[1] ? curValue[1] : `ADC_OFF_VALUE;
            `REG_CUR_ADC2:         readMux = chanSel[2] ? curValue[2] : `ADC_OFF_VALUE;
            `REG_CUR_ADC3:         readMux = chanSel[3] ? curValue[3] : `ADC_OFF_VALUE;
            default:               readMux = 8'h00;
        endcase
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            regRdData  <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                regRdData <= isLogAddr(regAddr) ? logMem[regAddr[10:0]] : readMux;
            end
        end
    end

    indicator_pulser #(
        .PULSE_CYC  (PULSE_CYC),
        .PERIOD_CYC (PERIOD_CYC)
    ) u_pulser (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .trigger   (startEvent),
        .inLimitN  (inLimitIndicatorN),
        .outLimitN (outLimitIndicatorN)
    );
endmodule

// ---- dv/datalog_sequencer_checker_asserts.sv ----
module datalog_sequencer_checker #(
    parameter integer PULSE_CYC = 4
) (
    input wire        clk_sys,            // clock
    input wire        rst_n,              // reset
    input wire        regWrEn,            // write
    input wire        regRdEn,            // read
    input wire [15:0] regAddr,            // address
    input wire [7:0]  regWrData,          // wdata
    input wire        regRdValid,         // rvalid
    input wire        startPinN,          // button
    input wire        convStart,          // conv req
    input wire [1:0]  convChannel,        // conv ch
    input wire        convDone,           // conv done
    input wire        missionActiveFlag,  // flag
    input wire        inLimitIndicatorN,  // ind a
    input wire        outLimitIndicatorN  // ind b
);
    timeunit 1ns;
    timeprecision 1ns;
    reg        seBit;
    reg [3:0]  sel;
    reg        pending;
    reg [23:0] lowCnt;
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            seBit <= 1'b0;
            sel <= 4'h1;
            pending <= 1'b0;
            lowCnt <= 24'h000000;
        end else begin
            if (regWrEn && regAddr == 16'h000E) seBit <= regWrData[0];
            if (regWrEn && regAddr == 16'h000F) sel <= regWrData[3:0];
            if (convStart) pending <= 1'b1;
            else if (convDone) pending <= 1'b0;
            lowCnt <= inLimitIndicatorN ? 24'h000000 : lowCnt + 24'h000001;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    chk_read_answer: assert property (regRdEn |=> regRdValid)
        else $error("read answer missing");
    chk_rate_start: assert property (!missionActiveFlag && !seBit && regWrEn
        && regAddr == 16'h000D && regWrData != 8'h00 |=> missionActiveFlag)
        else $error("rate write did not start");
    chk_button_armed: assert property (!missionActiveFlag && seBit && startPinN
        && regWrEn && regAddr == 16'h000D |=> !missionActiveFlag)
        else $error("started without press");
    chk_stop_write: assert property (missionActiveFlag && regWrEn
        && regAddr == 16'h0014 && !regWrData[5] |=> !missionActiveFlag)
        else $error("stop write ignored");
    chk_start_pulse: assert property ($rose(missionActiveFlag) |-> !inLimitIndicatorN)
        else $error("no pulse at start");
    chk_joint_pulse: assert property (inLimitIndicatorN == outLimitIndicatorN)
        else $error("indicators differ");
    chk_pulse_width: assert property ($rose(inLimitIndicatorN) |-> lowCnt == PULSE_CYC)
        else $error("pulse width wrong");
    chk_conv_serial: assert property (convStart |-> !pending)
        else $error("conversion overlap");
    chk_conv_enabled: assert property (convStart |-> sel[convChannel])
        else $error("disabled channel converted");
endmodule

bind datalog_mission_sequencer datalog_sequencer_checker #(.PULSE_CYC(PULSE_CYC)) chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdValid(regRdValid),
    .startPinN(startPinN), .convStart(convStart), .convChannel(convChannel),
    .convDone(convDone), .missionActiveFlag(missionActiveFlag),
    .inLimitIndicatorN(inLimitIndicatorN), .outLimitIndicatorN(outLimitIndicatorN));

// ---- dv/datalog_converter_model.sv ----
module datalog_converter_model (
    input  wire        clk_sys,      // clock
    input  wire        rst_n,        // reset
    input  wire        convStart,    // request
    input  wire [1:0]  convChannel,  // channel
    input  wire        slow,         // long conversions
    output reg         convDone,     // done pulse
    output reg  [7:0]  convData,     // result
    output reg  [11:0] convCount     // results given
);
    timeunit 1ns;
    timeprecision 1ns;
    reg       busy;
    reg [2:0] waitCnt;
    reg [1:0] ch;
    always @(posedge clk_sys) begin
        convDone <= 1'b0;
        if (!rst_n) begin
            busy <= 1'b0;
            convCount <= 12'h000;
            convData <= 8'h00;
        end else if (convStart) begin
            busy <= 1'b1;
            waitCnt <= slow ? 3'h6 : 3'h1;
            ch <= convChannel;
            convData <= ~convData;
        end else if (busy && waitCnt != 3'h0) begin
            waitCnt <= waitCnt - 3'h1;
            convData <= ~convData;
        end else if (busy) begin
            busy <= 1'b0;
            convDone <= 1'b1;
            convData <= {convCount[5:0] ^ convCount[11:6], ch};
            convCount <= convCount + 12'h001;
        end else begin
            convData <= ~convData;
        end
    end
endmodule

// ---- dv/datalog_mission_sequencer_test.sv ----
module datalog_mission_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    reg         clk_sys = 1'b0;
    reg         rst_n = 1'b0;
    reg         regWrEn = 1'b0;
    reg         regRdEn = 1'b0;
    reg  [15:0] regAddr = 16'h0000;
    reg  [7:0]  regWrData = 8'h00;
    reg         secRollover = 1'b0;
    reg  [23:0] rtcStamp = 24'h000000;
    reg         startPinN = 1'b1;
    reg         slow = 1'b1;
    wire [7:0]  regRdData;
    wire        regRdValid, convStart, convDone, missionActiveFlag, inN, outN;
    wire [1:0]  convChannel;
    wire [7:0]  convData;
    wire [11:0] convCount;
    integer     miscompares = 0;
    integer     nCompared = 0;
    integer     i;
    reg  [11:0] b;
    reg  [7:0]  d;
    logic [47:0] rows [0:5] = '{48'h0012_5A_0012_5A, 48'h0013_A5_0013_A5,
        48'h000F_00_0030_FF, 48'h000F_00_0033_00, 48'h000F_0F_000F_0F, 48'h0013_00_0013_00};
    always #20 clk_sys = ~clk_sys;
    datalog_mission_sequencer #(.PULSE_CYC(4), .PERIOD_CYC(16), .HOLD_CYC(8)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .secRollover(secRollover), .rtcStamp(rtcStamp),
        .startPinN(startPinN), .convStart(convStart), .convChannel(convChannel),
        .convDone(convDone), .convData(convData), .missionActiveFlag(missionActiveFlag),
        .inLimitIndicatorN(inN), .outLimitIndicatorN(outN));
    datalog_converter_model conv (.clk_sys(clk_sys), .rst_n(rst_n), .convStart(convStart),
        .convChannel(convChannel), .slow(slow), .convDone(convDone), .convData(convData),
        .convCount(convCount));
    function [7:0] f(input [11:0] n, input [1:0] ch);
        f = {n[5:0] ^ n[11:6], ch};
    endfunction
    task endOfTest;
        if (miscompares == 0 && nCompared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task tick;
        @(posedge clk_sys);
        #1;
    endtask
    task check(input [7:0] seen, input [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input [15:0] a, input [7:0] v);
        regAddr = a;
        regWrData = v;
        regWrEn = 1'b1;
        tick;
        regWrEn = 1'b0;
        tick;
    endtask
    task rc(input [15:0] a, input [7:0] e);
        regAddr = a;
        regRdEn = 1'b1;
        tick;
        regRdEn = 1'b0;
        check({7'h00, regRdValid}, 8'h01);
        d = regRdData;
        check(d, e);
        tick;
    endtask
    task flag(input e);
        rc(16'h0014, {2'h0, e, 5'h00});
    endtask
    task roll(input integer n);
        repeat (n) begin
            secRollover = 1'b1;
            tick;
            secRollover = 1'b0;
            repeat (60) tick;
        end
    endtask
    task full(input [7:0] ctl);
        wr(16'h000E, ctl);
        b = convCount;
        wr(16'h000D, 8'h01);
        roll(513);
        rc(16'h0018, 8'h04);
        rc(16'h0019, 8'h08);
        wr(16'h0014, 8'h00);
    endtask
    initial begin
        repeat (12) tick;
        rst_n = 1'b1;
        tick;
        rc(16'h000D, 8'h00);
        rc(16'h000F, 8'h01);
        rc(16'h0012, 8'h00);
        for (i = 0; i < 6; i++) begin
            wr(rows[i][47:32], rows[i][31:24]);
            rc(rows[i][23:8], rows[i][7:0]);
        end
        startPinN = 1'b0;
        repeat (12) tick;
        flag(1'b0);
        startPinN = 1'b1;
        wr(16'h0012, 8'h01);
        wr(16'h000F, 8'h07);
        b = convCount;
        wr(16'h000D, 8'h01);
        flag(1'b1);
        rtcStamp = 24'h123456;
        roll(1);
        rc(16'h0012, 8'h00);
        rc(16'h0018, 8'h00);
        roll(1);
        rtcStamp = 24'h654321;
        for (i = 0; i < 3; i++) rc(16'h1000 + i, f(b + i, i));
        rc(16'h1003, 8'h00);
        wr(16'h1000, 8'h55);
        rc(16'h1000, f(b, 2'h0));
        roll(1);
        rc(16'h1004, f(b + 12'h003, 2'h0));
        rc(16'h0018, 8'h08);
        rc(16'h001C, 8'h56);
        rc(16'h001E, 8'h12);
        wr(16'h0014, 8'h00);
        flag(1'b0);
        wr(16'h000E, 8'h01);
        wr(16'h000D, 8'h02);
        flag(1'b0);
        startPinN = 1'b0;
        repeat (12) tick;
        flag(1'b1);
        startPinN = 1'b1;
        wr(16'h0014, 8'h00);
        repeat (80) tick;
        slow = 1'b0;
        wr(16'h000F, 8'h0F);
        full(8'h00);
        rc(16'h1000, f(b, 2'h0));
        rc(16'h17FF, f(b + 12'h7FF, 2'h3));
        full(8'h08);
        rc(16'h1000, f(b + 12'h800, 2'h0));
        rc(16'h1001, f(b + 12'h801, 2'h1));
        wr(16'h000E, 8'h01);
        wr(16'h000D, 8'h03);
        flag(1'b0);
        wr(16'h000E, 8'h00);
        wr(16'h000D, 8'h03);
        flag(1'b1);
        endOfTest;
    end
endmodule
